// ### design/adc_cfg_pkg.sv
/*
  Shared constants, types and helpers for the converter input mode and
  comparator limit register block.
  Assumes a single 100 MHz clock and byte offsets inside a 64-byte window.
*/
package adc_cfg_pkg;

  localparam int NUM_INPUTS = 16;
  localparam int NUM_CMP = 6;
  localparam int LIMIT_W = 16;

  // Byte offsets inside the block window
  localparam logic [5:0] OFS_INPUT_MODE = 6'h00;
  localparam logic [5:0] OFS_LIMIT_FIRST = 6'h04;
  localparam logic [5:0] OFS_LIMIT_LAST = 6'h18;
  localparam logic [5:0] OFS_COMP_ENABLE = 6'h1C;
  localparam logic [5:0] OFS_LIMIT_FAULT = 6'h20;

  // Field positions: pair of bits per input, limits in halves
  localparam int DIFF_BIT_OFS = 1;
  localparam int SIGN_BIT_OFS = 0;
  localparam int HI_LSB = 16;
  localparam int LO_LSB = 0;

  localparam logic [31:0] RST_INPUT_MODE = 32'h0000_0000;
  localparam logic [31:0] RST_LIMIT = 32'h0000_0000;
  localparam logic [5:0] RST_COMP_ENABLE = 6'h00;
  localparam logic [5:0] RST_LIMIT_FAULT = 6'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam int HTRANS_ACTIVE_BIT = 1;

  typedef logic [31:0] word_t;
  typedef logic [LIMIT_W-1:0] limit_t;
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} phase_t;

  function automatic word_t merge_bytes(word_t old_w, word_t new_w, logic [3:0] be);
    word_t res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

endpackage : adc_cfg_pkg

// ### design/ahb_lite_port.sv
/*
  AHB-Lite slave front end: captures the address phase and produces
  write and read strobes for the data phase.
  Assumes this slave's hreadyout is returned as the bus hready.
*/
`timescale 1ns/10ps
module ahb_lite_port (
  input wire logic core_clk_in, // 100 MHz clock
  input wire logic resetn_in, // Synchronous reset, active low
  input wire logic hsel_in, // Slave select
  input wire logic [31:0] haddr_in, // Byte address
  input wire logic [1:0] htrans_in, // Transfer type
  input wire logic hwrite_in, // Write when high
  input wire logic [2:0] hsize_in, // Transfer size
  input wire logic hready_in, // Bus ready
  output logic hreadyout_out, // Slave ready
  output logic hresp_out, // Always OKAY
  output logic wr_en_out, // Write data phase
  output logic rd_en_out, // Read wait cycle
  output logic [5:0] addr_out, // Latched byte offset
  output logic [3:0] be_out // Latched byte lanes
);
  import adc_cfg_pkg::*;

  phase_t phase_r;
  phase_t phase_nxt;
  logic [5:0] addr_r;
  logic [3:0] be_r;
  logic take;

  function automatic logic [3:0] lane_mask(logic [2:0] size, logic [1:0] a);
    logic [3:0] m;
    m = 4'hF;
    if (size == HSIZE_BYTE) begin
      m = 4'h1 << a;
    end else if (size == HSIZE_HALF) begin
      m = a[1] ? 4'hC : 4'h3;
    end
    return m;
  endfunction : lane_mask

  assign take = hsel_in & hready_in & htrans_in[HTRANS_ACTIVE_BIT];
  assign phase_nxt = take ? (hwrite_in ? PH_WRITE : PH_READ) : PH_IDLE;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      phase_r <= PH_IDLE;
      addr_r <= 6'h00;
      be_r <= 4'h0;
    end else begin
      phase_r <= phase_nxt;
      if (take) begin
        addr_r <= haddr_in[5:0];
        be_r <= lane_mask(hsize_in, haddr_in[1:0]);
      end
    end
  end

  // One wait state on reads so a write just before is already visible
  assign hreadyout_out = (phase_r != PH_READ);
  assign hresp_out = 1'b0;
  assign wr_en_out = (phase_r == PH_WRITE);
  assign rd_en_out = (phase_r == PH_READ);
  assign addr_out = addr_r;
  assign be_out = be_r;

endmodule : ahb_lite_port

// ### design/limit_bank.sv
/*
  Six comparator limit words, each a high and a low 16-bit limit.
  Assumes writes arrive as one-cycle strobes with byte lanes.
*/
`timescale 1ns/10ps
module limit_bank (
  input wire logic core_clk_in, // 100 MHz clock
  input wire logic resetn_in, // Synchronous reset, active low
  input wire logic wr_en_in, // Limit write strobe
  input wire logic [2:0] slot_in, // Comparator index
  input wire logic [3:0] be_in, // Byte lanes
  input wire adc_cfg_pkg::word_t wdata_in, // Write data
  input wire logic [adc_cfg_pkg::NUM_CMP-1:0] enable_in, // Comparator enables
  output adc_cfg_pkg::word_t [adc_cfg_pkg::NUM_CMP-1:0] limit_word_out, // Readback
  output adc_cfg_pkg::limit_t [adc_cfg_pkg::NUM_CMP-1:0] high_out, // High limits
  output adc_cfg_pkg::limit_t [adc_cfg_pkg::NUM_CMP-1:0] low_out, // Low limits
  output logic [adc_cfg_pkg::NUM_CMP-1:0] violation_out // Write while enabled
);
  import adc_cfg_pkg::*;

  genvar k;
  generate
    for (k = 0; k < NUM_CMP; k++) begin : g_slot
      word_t limit_r;
      logic hit;
      assign hit = wr_en_in && (slot_in == 3'(k));
      always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
          limit_r <= RST_LIMIT;
        end else if (hit) begin
          limit_r <= merge_bytes(limit_r, wdata_in, be_in);
        end
      end
      assign high_out[k] = limit_r[HI_LSB +: LIMIT_W];
      assign low_out[k] = limit_r[LO_LSB +: LIMIT_W];
      assign limit_word_out[k] = limit_r;
      assign violation_out[k] = hit && enable_in[k];
    end
  endgenerate

endmodule : limit_bank

// ### design/adc_input_mode_and_compare_limits.sv
/*
  Converter configuration registers: per-input mode and sign bits for
  inputs 16 to 31, six comparator limit words, comparator enables and a
  sticky flag of limit writes made while the written word's comparator was enabled.
  Assumes an AHB-Lite master with single word-or-smaller transfers and
  that this slave's hreadyout is fed back as hready.
*/
// How it works
// - odd bit of pair selects differential input
// - bit below it selects signed results
// - upper half holds 16-bit high limit
// - lower half holds 16-bit low limit
`timescale 1ns/10ps
module adc_input_mode_and_compare_limits (
  input wire logic core_clk_in, // 100 MHz clock
  input wire logic resetn_in, // Synchronous reset, active low
  input wire logic hsel_in, // AHB slave select
  input wire logic [31:0] haddr_in, // AHB byte address
  input wire logic [1:0] htrans_in, // AHB transfer type
  input wire logic hwrite_in, // AHB write
  input wire logic [2:0] hsize_in, // AHB size
  input wire adc_cfg_pkg::word_t hwdata_in, // AHB write data
  input wire logic hready_in, // AHB bus ready
  output adc_cfg_pkg::word_t hrdata_out, // AHB read data
  output logic hreadyout_out, // AHB slave ready
  output logic hresp_out, // AHB response
  output logic [adc_cfg_pkg::NUM_INPUTS-1:0] input_differential_select_out, // Inputs 16-31
  output logic [adc_cfg_pkg::NUM_INPUTS-1:0] input_signed_select_out, // Inputs 16-31
  output adc_cfg_pkg::limit_t [adc_cfg_pkg::NUM_CMP-1:0] compare_high_limit_out, // High
  output adc_cfg_pkg::limit_t [adc_cfg_pkg::NUM_CMP-1:0] compare_low_limit_out, // Low
  output logic [adc_cfg_pkg::NUM_CMP-1:0] comparator_enable_bit_out // Enables
);
  import adc_cfg_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Bus front end

  logic wr_en;
  logic rd_en;
  logic [5:0] addr;
  logic [3:0] be;

  ahb_lite_port u_port (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hready_in(hready_in),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .wr_en_out(wr_en),
    .rd_en_out(rd_en),
    .addr_out(addr),
    .be_out(be)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by reads and writes

  function automatic logic word_hit(logic [5:0] a, logic [5:0] ofs);
    return a[5:2] == ofs[5:2];
  endfunction : word_hit

  function automatic logic limit_hit(logic [5:0] a);
    return (a[5:2] >= OFS_LIMIT_FIRST[5:2]) && (a[5:2] <= OFS_LIMIT_LAST[5:2]);
  endfunction : limit_hit

  logic sel_mode;
  logic sel_limit;
  logic sel_enable;
  logic sel_fault;
  logic [3:0] slot_wide;
  logic [2:0] slot;

  assign sel_mode = word_hit(addr, OFS_INPUT_MODE);
  assign sel_limit = limit_hit(addr);
  assign sel_enable = word_hit(addr, OFS_COMP_ENABLE);
  assign sel_fault = word_hit(addr, OFS_LIMIT_FAULT);
  assign slot_wide = addr[5:2] - OFS_LIMIT_FIRST[5:2];
  assign slot = slot_wide[2:0];

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  word_t mode_r;
  word_t mode_nxt;
  logic [NUM_CMP-1:0] enable_r;
  logic [NUM_CMP-1:0] enable_nxt;
  logic [NUM_CMP-1:0] fault_r;
  logic [NUM_CMP-1:0] fault_nxt;
  logic [NUM_CMP-1:0] fault_clr;
  logic [NUM_CMP-1:0] violation;
  word_t hrdata_r;
  word_t rd_word;
  word_t enable_word;
  word_t fault_word;
  word_t [NUM_CMP-1:0] limit_word;

  assign mode_nxt = (wr_en && sel_mode) ? merge_bytes(mode_r, hwdata_in, be) : mode_r;
  assign enable_word = word_t'(enable_r);
  assign fault_word = word_t'(fault_r);
  assign enable_nxt = (wr_en && sel_enable) ?
                      NUM_CMP'(merge_bytes(enable_word, hwdata_in, be)) : enable_r;
  assign fault_clr = (wr_en && sel_fault && be[0]) ? hwdata_in[NUM_CMP-1:0] : '0;
  // A new violation outranks a clear in the same cycle
  assign fault_nxt = (fault_r & ~fault_clr) | violation;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      mode_r <= RST_INPUT_MODE;
      enable_r <= RST_COMP_ENABLE;
      fault_r <= RST_LIMIT_FAULT;
    end else begin
      mode_r <= mode_nxt;
      enable_r <= enable_nxt;
      fault_r <= fault_nxt;
    end
  end

  limit_bank u_limits (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(wr_en && sel_limit),
    .slot_in(slot),
    .be_in(be),
    .wdata_in(hwdata_in),
    .enable_in(enable_r),
    .limit_word_out(limit_word),
    .high_out(compare_high_limit_out),
    .low_out(compare_low_limit_out),
    .violation_out(violation)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped offsets read zero

  assign rd_word = sel_mode ? mode_r :
                   sel_limit ? limit_word[slot] :
                   sel_enable ? enable_word :
                   sel_fault ? fault_word : RST_RDATA;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      hrdata_r <= RST_RDATA;
    end else if (rd_en) begin
      hrdata_r <= rd_word;
    end
  end

  assign hrdata_out = hrdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // Per-input mode outputs

  genvar i;
  generate
    for (i = 0; i < NUM_INPUTS; i++) begin : g_input
      assign input_differential_select_out[i] = mode_r[2*i + DIFF_BIT_OFS];
      assign input_signed_select_out[i] = mode_r[2*i + SIGN_BIT_OFS];
    end
  endgenerate

  assign comparator_enable_bit_out = enable_r;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic a_take;
  logic a_full_wr;
  assign a_take = hsel_in && hready_in && htrans_in[HTRANS_ACTIVE_BIT];
  assign a_full_wr = wr_en && (be == 4'hF);

  sequence s_read_wait;
    !hreadyout_out ##1 hreadyout_out;
  endsequence

  sequence s_read_take;
    a_take && !hwrite_in;
  endsequence

  property p_diff_write;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (a_full_wr && sel_mode) |=>
      (input_differential_select_out[15] == $past(hwdata_in[31])) &&
      (input_differential_select_out[0] == $past(hwdata_in[1]));
  endproperty
  a_diff_write: assert property (p_diff_write)
    else $error("differential select does not follow written odd bit");

  property p_sign_write;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (a_full_wr && sel_mode) |=>
      (input_signed_select_out[15] == $past(hwdata_in[30])) &&
      (input_signed_select_out[0] == $past(hwdata_in[0]));
  endproperty
  a_sign_write: assert property (p_sign_write)
    else $error("signed select does not follow written even bit");

  property p_high_write;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (a_full_wr && sel_limit) |=>
      (compare_high_limit_out[$past(slot)] == $past(hwdata_in[31:16]));
  endproperty
  a_high_write: assert property (p_high_write)
    else $error("high limit not taken from upper half");

  property p_low_write;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (a_full_wr && sel_limit) |=>
      (compare_low_limit_out[$past(slot)] == $past(hwdata_in[15:0]));
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("low limit not taken from lower half");

  property p_reset_zero;
    @(posedge core_clk_in) disable iff (!resetn_in)
    $rose(resetn_in) |->
      (mode_r == RST_INPUT_MODE) && (compare_high_limit_out == '0) &&
      (compare_low_limit_out == '0) && (enable_r == RST_COMP_ENABLE);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("fields not zero after reset");

  property p_fault_set;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (wr_en && sel_limit && enable_r[slot]) |=> fault_r[$past(slot)];
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("limit write while enabled not flagged");

  property p_mode_stable;
    @(posedge core_clk_in) disable iff (!resetn_in)
    !(wr_en && sel_mode) |=> $stable(mode_r);
  endproperty
  a_mode_stable: assert property (p_mode_stable)
    else $error("mode register changed without a write");

  property p_read_wait;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_read_take |=> s_read_wait;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read did not take exactly one wait state");

  property p_read_mode;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (s_read_take and (haddr_in[5:2] == OFS_INPUT_MODE[5:2])) |-> ##2
      (hrdata_out == $past(mode_r));
  endproperty
  a_read_mode: assert property (p_read_mode)
    else $error("mode readback wrong");

  property p_unmapped_zero;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (s_read_take and (haddr_in[5:2] > OFS_LIMIT_FAULT[5:2])) |-> ##2 (hrdata_out == '0);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_write_ready;
    @(posedge core_clk_in) disable iff (!resetn_in)
    wr_en |-> (hreadyout_out && !hresp_out);
  endproperty
  a_write_ready: assert property (p_write_ready)
    else $error("write data phase stalled or errored");

  property p_enable_write;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (a_full_wr && sel_enable) |=>
      (comparator_enable_bit_out == $past(hwdata_in[NUM_CMP-1:0]));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable bits do not follow written word");

  property p_fault_clear;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (wr_en && sel_fault && be[0] && (violation == '0)) |=>
      ((fault_r & $past(hwdata_in[NUM_CMP-1:0])) == '0);
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault bit written with one not cleared");

  property p_limit_stable;
    @(posedge core_clk_in) disable iff (!resetn_in)
    !(wr_en && sel_limit) |=>
      ($stable(compare_high_limit_out) && $stable(compare_low_limit_out));
  endproperty
  a_limit_stable: assert property (p_limit_stable)
    else $error("limits changed without a limit write");

  // Checked during reset itself, so no disable here
  property p_reset_clears;
    @(posedge core_clk_in)
    !resetn_in |=> (mode_r == RST_INPUT_MODE) && (enable_r == RST_COMP_ENABLE) &&
      (fault_r == RST_LIMIT_FAULT) && (hrdata_out == RST_RDATA);
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("registers not cleared while reset held");

endmodule : adc_input_mode_and_compare_limits

// ### bench/adc_input_mode_and_compare_limits_tb.sv
/*
  Self-checking bench for the converter mode and comparator limit block.
  Assumes AHB-Lite single word transfers, hready fed back from hreadyout.
*/
`timescale 1ns/10ps
module adc_input_mode_and_compare_limits_tb;
  import adc_cfg_pkg::*;

  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0000_0000;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'h2;
  word_t hwdata_in = 32'h0000_0000;
  word_t hrdata_out;
  logic hreadyout_out;
  logic hresp_out;
  logic [NUM_INPUTS-1:0] diff_sel;
  logic [NUM_INPUTS-1:0] sign_sel;
  limit_t [NUM_CMP-1:0] hi_lim;
  limit_t [NUM_CMP-1:0] lo_lim;
  logic [NUM_CMP-1:0] cmp_en;
  int errors = 0;
  int check_count = 0;
  word_t rd;
  word_t w;
  logic [NUM_INPUTS-1:0] dx;
  logic [NUM_INPUTS-1:0] sx;

  adc_input_mode_and_compare_limits uut (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .input_differential_select_out(diff_sel),
    .input_signed_select_out(sign_sel),
    .compare_high_limit_out(hi_lim),
    .compare_low_limit_out(lo_lim),
    .comparator_enable_bit_out(cmp_en)
  );

  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checks=%0d mismatches=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  task chk(input word_t got, input word_t exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Level at the falling edge is what the next rising edge samples
  task wait_rdy;
    int n;
    n = 0;
    @(negedge core_clk_in);
    while (hreadyout_out !== 1'b1 && n < 50) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n >= 50) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, hreadyout_out, 1'b1);
      summarize();
    end
  endtask : wait_rdy

  task bus_xfer(input logic wr, input logic [5:0] ofs, input word_t d, output word_t q);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {26'h000_0000, ofs};
    hwrite_in <= wr;
    hsize_in <= 3'h2;
    wait_rdy();
    @(posedge core_clk_in);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    wait_rdy();
    q = hrdata_out;
    chk({31'h0, hresp_out}, 32'h0000_0000);
    @(posedge core_clk_in);
  endtask : bus_xfer

  task wr_reg(input logic [5:0] ofs, input word_t d);
    word_t q;
    bus_xfer(1'b1, ofs, d, q);
  endtask : wr_reg

  task rd_reg(input logic [5:0] ofs, output word_t q);
    bus_xfer(1'b0, ofs, 32'h0000_0000, q);
  endtask : rd_reg

  task check_mode(input word_t m);
    wr_reg(OFS_INPUT_MODE, m);
    rd_reg(OFS_INPUT_MODE, rd);
    chk(rd, m);
    for (int j = 0; j < NUM_INPUTS; j++) begin
      dx[j] = m[2*j+1];
      sx[j] = m[2*j];
    end
    chk({16'h0000, diff_sel}, {16'h0000, dx});
    chk({16'h0000, sign_sel}, {16'h0000, sx});
  endtask : check_mode

  task check_zero_state;
    for (int a = 0; a < 10; a++) begin
      rd_reg(6'(4*a), rd);
      chk(rd, 32'h0000_0000);
    end
    chk({diff_sel, sign_sel}, 32'h0000_0000);
    chk({26'h0, cmp_en}, 32'h0000_0000);
    for (int k = 0; k < NUM_CMP; k++) begin
      chk({hi_lim[k], lo_lim[k]}, 32'h0000_0000);
    end
  endtask : check_zero_state

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    @(posedge core_clk_in);
    check_zero_state();
    $display("test reset_values done");

    for (int i = 0; i < 32; i++) begin
      check_mode(32'h0000_0001 << i);
    end
    check_mode(32'hA5C3_9E61);
    $display("test input_mode done");

    for (int k = 0; k < NUM_CMP; k++) begin
      wr_reg(6'(OFS_LIMIT_FIRST + 4*k), {12'hC3A, 4'(k), 4'(k), 12'h5B7});
    end
    for (int k = 0; k < NUM_CMP; k++) begin
      w = {12'hC3A, 4'(k), 4'(k), 12'h5B7};
      rd_reg(6'(OFS_LIMIT_FIRST + 4*k), rd);
      chk(rd, w);
      chk({16'h0000, hi_lim[k]}, {16'h0000, w[31:16]});
      chk({16'h0000, lo_lim[k]}, {16'h0000, w[15:0]});
    end
    $display("test limits done");

    wr_reg(OFS_COMP_ENABLE, 32'hFFFF_FFFF);
    rd_reg(OFS_COMP_ENABLE, rd);
    chk(rd, 32'h0000_003F);
    chk({26'h0, cmp_en}, 32'h0000_003F);
    wr_reg(OFS_LIMIT_FIRST + 6'h08, 32'h1234_ABCD);
    rd_reg(OFS_LIMIT_FAULT, rd);
    chk(rd, 32'h0000_0004);
    chk({hi_lim[2], lo_lim[2]}, 32'h1234_ABCD);
    wr_reg(OFS_LIMIT_FAULT, 32'h0000_0004);
    rd_reg(OFS_LIMIT_FAULT, rd);
    chk(rd, 32'h0000_0000);
    wr_reg(OFS_COMP_ENABLE, 32'h0000_0000);
    wr_reg(OFS_LIMIT_FIRST, 32'h0F0F_F0F0);
    rd_reg(OFS_LIMIT_FAULT, rd);
    chk(rd, 32'h0000_0000);
    $display("test enable_fault done");

    // Signed results everywhere, so limits go in signed; enables are off
    check_mode(32'h5555_5555);
    wr_reg(OFS_LIMIT_FIRST, 32'h0100_FF00);
    rd_reg(OFS_LIMIT_FIRST, rd);
    chk(rd, 32'h0100_FF00);
    chk({hi_lim[0], lo_lim[0]}, 32'h0100_FF00);
    $display("test signed_limits done");

    // Unmapped space reads zero and swallows writes
    wr_reg(6'h24, 32'hFFFF_FFFF);
    rd_reg(6'h24, rd);
    chk(rd, 32'h0000_0000);
    rd_reg(6'h3C, rd);
    chk(rd, 32'h0000_0000);
    $display("test unmapped done");

    // Second reset mid-run clears everything written above
    resetn_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    @(posedge core_clk_in);
    check_zero_state();
    $display("test second_reset done");
    summarize();
  end
endmodule : adc_input_mode_and_compare_limits_tb
